// ---- dv/cmx_mixer_regs_assertions.sv ----
// Port-level concurrent checks of the mixer control bank
`timescale 1ns/1ps
module cmx_mixer_regs_assertions #(
    parameter int ADR_W        = 8,
    parameter int DEFER_CYCLES = 20
) (
    input wire logic                          CLK_IN,                    // Clock
    input wire logic                          RST_IN,                    // Sync reset
    input wire logic                          PWR_DOWN_N_IN,             // Power-down pin
    input wire logic                          WB_CYC_IN,                 // Bus cycle
    input wire logic                          WB_STB_IN,                 // Strobe
    input wire logic                          WB_WE_IN,                  // Write enable
    input wire logic [ADR_W-1:0]              WB_ADR_IN,                 // Byte address
    input wire logic [31:0]                   WB_DAT_OUT,                // Read data
    input wire logic                          WB_ACK_OUT,                // Acknowledge
    input wire logic                          DAC_B_ZERO_CROSS_IN,       // DAC B midscale
    input wire logic [15:0]                   DAC_B_GAIN_IN,             // DAC B word
    input wire logic                          DAC_B_GAIN_LOAD_IN,        // DAC B load
    input wire cmx_pkg::cmx_mix_s [1:0]       MIC_MIX_OUT,               // Mic mix
    input wire cmx_pkg::cmx_mix_s             RIGHT_AUX3_MIX_OUT,        // Aux3 mix
    input wire cmx_pkg::cmx_mix_s             MONO_IN_MIX_OUT,           // Mono mix
    input wire logic                          SUMMING_PINS_MIX_MUTE_OUT, // Sum mute
    input wire logic                          GLOBAL_MIX_MUTE_OUT,       // Global mute
    input wire logic                          MONO_OUT_MUTE_OUT,         // Mono out mute
    input wire logic                          HEADPHONE_OUT_MUTE_OUT,    // Phones mute
    input wire logic                          HEADPHONE_SWING_OUT,       // Phones swing
    input wire cmx_pkg::cmx_dac_split_s [1:0] DAC_A_OUT,                 // DAC A split
    input wire logic [15:0]                   DAC_B_GAIN_OUT             // DAC B applied
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    // Request steps, a DAC B load and a held midscale crossing
    sequence s_req;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    endsequence
    sequence s_b_load;
        DAC_B_GAIN_LOAD_IN && PWR_DOWN_N_IN;
    endsequence
    sequence s_b_cross;
        (DAC_B_ZERO_CROSS_IN && !DAC_B_GAIN_LOAD_IN && PWR_DOWN_N_IN) [*3];
    endsequence

    AST_ACK_NEXT: assert property (s_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
        else $error("ack not a single pulse one cycle after request");
    AST_DAT_IDLE: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
        else $error("read data not zero outside ack");
    AST_UNMAPPED: assert property (s_req and !WB_WE_IN && WB_ADR_IN[7:2] == 6'h00
        |=> WB_DAT_OUT == 32'h0)
        else $error("unmapped read returned data");
    AST_MIC_RSVD: assert property (s_req and !WB_WE_IN && WB_ADR_IN[7:2] == 6'h07
        |=> (WB_DAT_OUT & 32'hffff6060) == 32'h0)
        else $error("reserved mic bits read nonzero");
    AST_RST_DEF: assert property ($fell(RST_IN)
        |-> MIC_MIX_OUT == 12'ha28 && DAC_A_OUT == 24'ha00a00)
        else $error("mic or dac defaults wrong after reset");
    AST_RST_MISC: assert property ($fell(RST_IN)
        |-> {GLOBAL_MIX_MUTE_OUT, MONO_OUT_MUTE_OUT, HEADPHONE_OUT_MUTE_OUT,
        HEADPHONE_SWING_OUT, SUMMING_PINS_MIX_MUTE_OUT, MONO_IN_MIX_OUT} == 11'h368)
        else $error("misc defaults wrong after reset");
    AST_PWR_HOLD: assert property (!PWR_DOWN_N_IN [*3]
        |-> MIC_MIX_OUT == 12'ha28 && MONO_OUT_MUTE_OUT)
        else $error("power-down did not hold defaults");
    AST_GLOBAL: assert property (GLOBAL_MIX_MUTE_OUT |-> MIC_MIX_OUT[1].mute
        && MIC_MIX_OUT[0].mute && RIGHT_AUX3_MIX_OUT.mute && MONO_IN_MIX_OUT.mute
        && SUMMING_PINS_MIX_MUTE_OUT)
        else $error("global mute left a mix open");
    AST_DAC_SPLIT: assert property (DAC_A_OUT[1].digital != 6'h0
        |-> DAC_A_OUT[1].analog == 5'h1f && DAC_A_OUT[1].digital <= 6'h20)
        else $error("digital step without full analog attenuation");
    AST_DAC_B_APPLY: assert property (s_b_load ##1 s_b_cross
        |=> DAC_B_GAIN_OUT == $past(DAC_B_GAIN_IN, 4))
        else $error("DAC B word not applied after crossing");
endmodule

bind cmx_mixer_regs cmx_mixer_regs_assertions #(.ADR_W(ADR_W), .DEFER_CYCLES(DEFER_CYCLES)) u_chk (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .PWR_DOWN_N_IN(PWR_DOWN_N_IN), .WB_CYC_IN(WB_CYC_IN),
    .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_OUT(WB_DAT_OUT),
    .WB_ACK_OUT(WB_ACK_OUT), .DAC_B_ZERO_CROSS_IN(DAC_B_ZERO_CROSS_IN),
    .DAC_B_GAIN_IN(DAC_B_GAIN_IN), .DAC_B_GAIN_LOAD_IN(DAC_B_GAIN_LOAD_IN),
    .MIC_MIX_OUT(MIC_MIX_OUT), .RIGHT_AUX3_MIX_OUT(RIGHT_AUX3_MIX_OUT),
    .MONO_IN_MIX_OUT(MONO_IN_MIX_OUT), .SUMMING_PINS_MIX_MUTE_OUT(SUMMING_PINS_MIX_MUTE_OUT),
    .GLOBAL_MIX_MUTE_OUT(GLOBAL_MIX_MUTE_OUT), .MONO_OUT_MUTE_OUT(MONO_OUT_MUTE_OUT),
    .HEADPHONE_OUT_MUTE_OUT(HEADPHONE_OUT_MUTE_OUT), .HEADPHONE_SWING_OUT(HEADPHONE_SWING_OUT),
    .DAC_A_OUT(DAC_A_OUT), .DAC_B_GAIN_OUT(DAC_B_GAIN_OUT));

// ---- dv/cmx_mixer_regs_tb.sv ----
// Self-checking bench for the mixer control register bank
`timescale 1ns/1ps
module cmx_mixer_regs_tb;
    localparam int DEFER = 20;                    // Short timeout keeps the run brief
    logic                          clk, rst, pwr_n, cyc, stb, we, ack, zca, zcb, bload;
    logic                          sum_mute, glob, mono_out, hp_mute, hp_swing;
    logic [7:0]                    adr;
    logic [3:0]                    sel;
    logic [15:0]                   bgain, dac_b;
    logic [31:0]                   dat_w, dat_r, rd;
    cmx_pkg::cmx_mix_s [1:0]       mic_mix;
    cmx_pkg::cmx_mix_s             aux3, mono_mix;
    cmx_pkg::cmx_dac_split_s [1:0] dac_a;
    int                            miscompares, tests_run, cycles;

    cmx_mixer_regs #(.ADR_W(8), .DEFER_CYCLES(DEFER)) DUT (
        .CLK_IN(clk), .RST_IN(rst), .PWR_DOWN_N_IN(pwr_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat_w), .WB_DAT_OUT(dat_r),
        .WB_ACK_OUT(ack), .DAC_A_ZERO_CROSS_IN(zca), .DAC_B_ZERO_CROSS_IN(zcb),
        .DAC_B_GAIN_IN(bgain), .DAC_B_GAIN_LOAD_IN(bload), .MIC_MIX_OUT(mic_mix),
        .RIGHT_AUX3_MIX_OUT(aux3), .MONO_IN_MIX_OUT(mono_mix),
        .SUMMING_PINS_MIX_MUTE_OUT(sum_mute), .GLOBAL_MIX_MUTE_OUT(glob),
        .MONO_OUT_MUTE_OUT(mono_out), .HEADPHONE_OUT_MUTE_OUT(hp_mute),
        .HEADPHONE_SWING_OUT(hp_swing), .DAC_A_OUT(dac_a), .DAC_B_GAIN_OUT(dac_b));

    // Free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; waits on ack, no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, dat_w} <= {1'b1, 1'b1, w, a, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = dat_r;
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [31:0] misc();
        return 32'({glob, mono_out, hp_mute, hp_swing, sum_mute});
    endfunction

    task automatic t_reset;
        rdc(8'h18, 32'h8888);
        rdc(8'h1c, 32'h8888);
        rdc(8'h20, 32'h8868);
        rdc(8'h24, 32'h8888);
        rdc(8'h00, 32'h0);
        chk(32'(dac_a), 32'ha00a00);
        chk(misc(), 32'h0d);
    endtask
    // Mix enables off, then DAC A enable off: only the low misc byte may change
    task automatic t_hold;
        wr(8'h1c, 32'h0);
        rdc(8'h1c, 32'h8888);
        wr(8'h20, 32'h0);
        rdc(8'h20, 32'h8800);
        wr(8'h6c, 32'h6);
        wr(8'h24, 32'h0);
        rdc(8'h24, 32'h8888);
    endtask
    task automatic t_mix;
        wr(8'h1c, 32'h9f9f);
        rdc(8'h1c, 32'h9f9f);
        wr(8'h1c, 32'h1f00);
        step(2);
        chk(32'(mic_mix), 32'h7c0);
        wr(8'h18, 32'h0011);
        step(2);
        chk(32'(aux3), 32'h11);
        wr(8'h20, 32'h0510);
        step(2);
        chk(32'(mono_mix), 32'h05);
        chk(misc(), 32'h02);
        wr(8'h20, 32'h0568);
        step(2);
        chk(misc(), 32'h0d);
        wr(8'h20, 32'h05e8);
        step(2);
        chk(32'(mic_mix), 32'hfe0);
        chk(32'({aux3, mono_mix}), 32'hc65);
    endtask
    // Immediate, crossing-timed, replaced and timed-out DAC A changes
    task automatic t_dac;
        wr(8'h6c, 32'he);
        wr(8'h20, 32'h0001);
        wr(8'h24, 32'h3f80);
        step(2);
        chk(32'(dac_a), 32'h7e0800);
        wr(8'h24, 32'h0820);
        step(2);
        chk(32'(dac_a), 32'h2007c1);
        wr(8'h20, 32'h0);
        wr(8'h24, 32'h0101);
        rdc(8'h70, 32'h1);
        step(2);
        chk(32'(dac_a), 32'h2007c1);
        wr(8'h24, 32'h0202);
        zca <= 1'b1;
        @(posedge clk);
        zca <= 1'b0;
        step(2);
        chk(32'(dac_a), 32'h080080);
        wr(8'h24, 32'h0303);
        step(DEFER - 6);
        chk(32'(dac_a), 32'h080080);
        step(8);
        chk(32'(dac_a), 32'h0c00c0);
    endtask
    task automatic t_dacb;
        {bgain, bload} <= {16'h1234, 1'b1};
        @(posedge clk);
        bload <= 1'b0;
        step(3);
        chk(32'(dac_b), 32'h8888);
        {bgain, bload} <= {16'h5678, 1'b1};
        @(posedge clk);
        {bload, zcb} <= 2'b01;
        step(3);
        zcb <= 1'b0;
        step(2);
        chk(32'(dac_b), 32'h5678);
        wr(8'h20, 32'h0002);
        {bgain, bload} <= {16'h4321, 1'b1};
        @(posedge clk);
        bload <= 1'b0;
        step(3);
        chk(32'(dac_b), 32'h4321);
    endtask
    // Conversions off, then power-down pin low, force defaults
    task automatic t_gate;
        wr(8'h6c, 32'h7);
        rdc(8'h1c, 32'h8888);
        rdc(8'h20, 32'h8868);
        wr(8'h6c, 32'h6);
        wr(8'h1c, 32'h0101);
        pwr_n <= 1'b0;
        step(3);
        chk(32'(mic_mix), 32'ha28);
        rdc(8'h1c, 32'h8888);
        pwr_n <= 1'b1;
    endtask

    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst, pwr_n, cyc, stb, we, zca, zcb, bload} <= 8'b11000000;
        {adr, sel, dat_w, bgain} <= {8'h0, 4'h3, 32'h0, 16'h0};
        miscompares = 0;
        tests_run = 0;
        step(10);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_hold();
        t_mix();
        t_dac();
        t_dacb();
        t_gate();
        final_report();
    end

    // Hang guard, well above the expected run length
    initial begin
        cycles = 0;
        while (cycles < 3000) begin
            @(posedge clk);
            cycles++;
        end
        miscompares++;
        $display("ERROR %0t: timeout", $time);
        final_report();
    end
endmodule

// ---- rtl/cmx_defs.svh ----
// Register indices, field positions, reset values and timing counts of the mixer control bank
`ifndef CMX_DEFS_SVH
`define CMX_DEFS_SVH

// Word indices; byte address is four times the index
`define CMX_IDX_AUX3        6'h06
`define CMX_IDX_MIC         6'h07
`define CMX_IDX_MONO        6'h08
`define CMX_IDX_DAC_A       6'h09
`define CMX_IDX_ENABLE      6'h1b
`define CMX_IDX_STATUS      6'h1c

// Reset values
`define CMX_RST_AUX3        16'h8888
`define CMX_RST_MIC         16'h8888
`define CMX_RST_MONO        16'h8868
`define CMX_RST_DAC_A       16'h8888
`define CMX_RST_DAC_B       16'h8888
`define CMX_RST_ENABLE      4'h0

// Writable bits; reserved bits stay zero
`define CMX_MASK_MIX        16'h9f9f
`define CMX_MASK_MONO       16'h9ffb
`define CMX_MASK_DAC        16'hbfbf

// Field positions inside one byte of a mix or gain register
`define CMX_MUTE_BIT        7
`define CMX_MIX_GAIN_MSB    4
`define CMX_DAC_GAIN_MSB    5

// Field positions in the low byte of the mono/misc register
`define CMX_GLOBAL_MUTE_BIT 7
`define CMX_MONO_OUT_BIT    6
`define CMX_HP_MUTE_BIT     5
`define CMX_HP_SWING_BIT    4
`define CMX_SUM_MUTE_BIT    3
`define CMX_DAC_B_TIME_BIT  1
`define CMX_DAC_A_TIME_BIT  0

// Enable register bits
`define CMX_EN_CONV_OFF_BIT 0
`define CMX_EN_AMIX_BIT     1
`define CMX_EN_ANA_BIT      2
`define CMX_EN_DAC_A_BIT    3

// Status register bits
`define CMX_ST_PEND_A_BIT   0
`define CMX_ST_PEND_B_BIT   1
`define CMX_ST_BASE_BIT     2
`define CMX_ST_MIX_BIT      3
`define CMX_ST_DAC_BIT      4

// Deferred gain change timeout, least figure, and clock rate
`define CMX_DEFER_TIMEOUT_MS 10
`define CMX_CLK_KHZ          125000
`define CMX_DEFER_CYCLES     (`CMX_DEFER_TIMEOUT_MS * `CMX_CLK_KHZ)

`endif

// ---- rtl/cmx_gain_defer.sv ----
// Deferred apply of a gain word on zero crossing or timeout
`timescale 1ns/1ps
module cmx_gain_defer #(
    parameter int          TIMEOUT_CYCLES = 1250000,
    parameter logic [15:0] RESET_VAL      = 16'h8888
) (
    input  wire logic        clk_in,       // Clock
    input  wire logic        rst_in,       // Synchronous reset
    input  wire logic        force_in,     // Hold applied word at default
    input  wire logic [15:0] value_in,     // Newly written gain word
    input  wire logic        load_in,      // Pulse: new word accepted
    input  wire logic        immediate_in, // 1: apply at once
    input  wire logic        zero_cross_in,// Output crossing midscale
    output logic      [15:0] applied_out,  // Gain word in force
    output logic             pending_out   // A change is waiting
);

    localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYCLES - 1);

    cmx_pkg::cmx_defer_e state;
    logic [15:0]         held;
    logic [CNT_W-1:0]    cnt;

    wire expire = (cnt == LAST);
    wire fire   = (state == cmx_pkg::CMX_WAIT) && (zero_cross_in || expire || immediate_in);

    // Newest write replaces a pending one and restarts the timeout
    always_ff @(posedge clk_in) begin
        if (rst_in || force_in) begin
            state       <= cmx_pkg::CMX_IDLE;
            held        <= RESET_VAL;
            cnt         <= '0;
            applied_out <= RESET_VAL;
        end else if (load_in) begin
            held <= value_in;
            cnt  <= '0;
            if (immediate_in) begin
                applied_out <= value_in;
                state       <= cmx_pkg::CMX_IDLE;
            end else begin
                state <= cmx_pkg::CMX_WAIT;
            end
        end else begin
            case (state)
                cmx_pkg::CMX_WAIT: begin
                    if (fire) begin
                        applied_out <= held;
                        state       <= cmx_pkg::CMX_IDLE;
                    end else begin
                        cnt <= cnt + CNT_W'(1);
                    end
                end
                default: begin
                    cnt <= '0;
                end
            endcase
        end
    end

    assign pending_out = (state == cmx_pkg::CMX_WAIT);

endmodule

// ---- rtl/cmx_mixer_regs.sv ----
// Mixer and output control register bank with Wishbone slave and deferred gain apply
//
// Function
// - Microphone mix mute per channel: 0 passes the mix, 1 silences it.
// - Microphone 5-bit gain steps -1.5 dB: 00000 +12, 01000 0, 11111 -34.5 dB.
// - Right aux3 mix has mute bit and 5-bit gain with same step encoding.
// - Aux3, microphone and DAC A gain registers reset to 0x8888.
// - Mono/misc register resets to 0x8868.
// - All but the enable register held at default, writes ignored in reset, power-down or conversions off; enable only resets.
// - Aux3 and microphone also held when analog mix or channels disabled.
// - Mono/misc upper byte only also held when analog mix or channels disabled.
// - DAC A gain also held when analog channels or DAC A disabled.
// - One mono mute and one mono gain serve both left and right mix.
// - Global mix mute silences every mix into DAC A outputs.
// - Mono output mute and headphone mute: 0 enables, 1 mutes.
// - Headphone swing select: 0 gives 2 V p-p, 1 gives 4 V p-p.
// - Summing pin mute: 0 mixes summing pins into DAC A, 1 mutes.
// - DAC A timing bit 1 applies gain at once, else on crossing or timeout.
// - DAC B timing bit works the same way for DAC B gain.
// - DAC A output mute per channel: 0 enables, 1 mutes.
// - DAC A 6-bit gain: top bit adds digital steps beyond -34.5 dB analog.
`timescale 1ns/1ps
`include "cmx_defs.svh"
module cmx_mixer_regs #(
    parameter int ADR_W          = 8,
    parameter int DEFER_CYCLES   = `CMX_DEFER_CYCLES
) (
    input  wire logic                       CLK_IN,                    // 125 MHz clock
    input  wire logic                       RST_IN,                    // Sync reset, high
    input  wire logic                       PWR_DOWN_N_IN,             // Power-down pin, low
    input  wire logic                       WB_CYC_IN,                 // Bus cycle
    input  wire logic                       WB_STB_IN,                 // Strobe
    input  wire logic                       WB_WE_IN,                  // Write enable
    input  wire logic [ADR_W-1:0]           WB_ADR_IN,                 // Byte address
    input  wire logic [3:0]                 WB_SEL_IN,                 // Byte enables
    input  wire logic [31:0]                WB_DAT_IN,                 // Write data
    output logic      [31:0]                WB_DAT_OUT,                // Read data
    output logic                            WB_ACK_OUT,                // Acknowledge
    input  wire logic                       DAC_A_ZERO_CROSS_IN,       // DAC A at midscale
    input  wire logic                       DAC_B_ZERO_CROSS_IN,       // DAC B at midscale
    input  wire logic [15:0]                DAC_B_GAIN_IN,             // DAC B gain word
    input  wire logic                       DAC_B_GAIN_LOAD_IN,        // DAC B word written
    output cmx_pkg::cmx_mix_s [1:0]         MIC_MIX_OUT,               // 1 left, 0 right
    output cmx_pkg::cmx_mix_s               RIGHT_AUX3_MIX_OUT,        // Right aux3 mix
    output cmx_pkg::cmx_mix_s               MONO_IN_MIX_OUT,           // Mono into both
    output logic                            SUMMING_PINS_MIX_MUTE_OUT, // Summing pins muted
    output logic                            GLOBAL_MIX_MUTE_OUT,       // All mix muted
    output logic                            MONO_OUT_MUTE_OUT,         // Mono output muted
    output logic                            HEADPHONE_OUT_MUTE_OUT,    // Headphones muted
    output logic                            HEADPHONE_SWING_OUT,       // 1: 4 V p-p
    output cmx_pkg::cmx_dac_split_s [1:0]   DAC_A_OUT,                 // 1 left, 0 right
    output logic      [15:0]                DAC_B_GAIN_OUT             // DAC B word in force
);

    localparam int IDX_W = ADR_W - 2;

    // Byte-lane merge limited to writable bits
    function automatic logic [15:0] cmx_merge(
        input logic [15:0] old_val,
        input logic [15:0] wr_val,
        input logic [1:0]  sel,
        input logic [15:0] mask
    );
        logic [15:0] lanes;
        lanes = mask & {{8{sel[1]}}, {8{sel[0]}}};
        return (old_val & ~lanes) | (wr_val & lanes);
    endfunction

    // Register storage
    logic [15:0] aux3;
    logic [15:0] mic;
    logic [15:0] mono;
    logic [15:0] dac_a;
    logic [3:0]  enable;
    logic [31:0] rd_data;
    logic [15:0] dac_a_applied;
    logic [15:0] dac_b_applied;
    logic        pend_a;
    logic        pend_b;

    // Bus decode; a write lands on the edge where the master sees ack
    wire [IDX_W-1:0] idx       = WB_ADR_IN[ADR_W-1:2];
    wire             req       = WB_CYC_IN && WB_STB_IN;
    wire             commit    = req && WB_WE_IN && WB_ACK_OUT;
    wire             hit_aux3  = (idx == `CMX_IDX_AUX3);
    wire             hit_mic   = (idx == `CMX_IDX_MIC);
    wire             hit_mono  = (idx == `CMX_IDX_MONO);
    wire             hit_dac_a = (idx == `CMX_IDX_DAC_A);
    wire             hit_en    = (idx == `CMX_IDX_ENABLE);
    wire             hit_st    = (idx == `CMX_IDX_STATUS);
    wire             lane_any  = WB_SEL_IN[0] || WB_SEL_IN[1];
    wire [15:0]      wr_word   = WB_DAT_IN[15:0];
    wire [1:0]       wr_sel    = WB_SEL_IN[1:0];

    // Enable bits that gate the mixing registers
    wire conv_off  = enable[`CMX_EN_CONV_OFF_BIT];
    wire amix_en   = enable[`CMX_EN_AMIX_BIT];
    wire ana_en    = enable[`CMX_EN_ANA_BIT];
    wire dac_a_en  = enable[`CMX_EN_DAC_A_BIT];

    // Hold conditions; each clears to default and blocks writes
    wire base_hold = RST_IN || !PWR_DOWN_N_IN || conv_off;
    wire mix_hold  = base_hold || !amix_en || !ana_en;
    wire dac_hold  = base_hold || !ana_en || !dac_a_en;

    // Write strobes per register
    wire wr_aux3   = commit && hit_aux3;
    wire wr_mic    = commit && hit_mic;
    wire wr_mono   = commit && hit_mono;
    wire wr_dac_a  = commit && hit_dac_a;
    wire wr_en     = commit && hit_en;
    wire dac_a_ld  = wr_dac_a && lane_any && !dac_hold;

    // Reserved bits never store, so they always read back as zero
    wire [15:0] aux3_merge  = cmx_merge(aux3, wr_word, wr_sel, `CMX_MASK_MIX);
    wire [15:0] mic_merge   = cmx_merge(mic, wr_word, wr_sel, `CMX_MASK_MIX);
    wire [15:0] mono_merge  = cmx_merge(mono, wr_word, wr_sel, `CMX_MASK_MONO);
    wire [15:0] dac_merge   = cmx_merge(dac_a, wr_word, wr_sel, `CMX_MASK_DAC);
    wire [15:0] rst_mono    = `CMX_RST_MONO;

    // Next register values
    wire [15:0] next_aux3;
    wire [15:0] next_mic;
    wire [15:0] next_mono;
    wire [15:0] next_dac_a;
    wire [3:0]  next_enable;
    wire [15:0] mono_wr;

    assign next_aux3   = mix_hold ? `CMX_RST_AUX3 : (wr_aux3 ? aux3_merge : aux3);
    assign next_mic    = mix_hold ? `CMX_RST_MIC : (wr_mic ? mic_merge : mic);
    assign mono_wr     = wr_mono ? mono_merge : mono;
    // Upper byte follows the mix gate, lower byte only the base gate
    assign next_mono   = {mix_hold ? rst_mono[15:8] : mono_wr[15:8],
                          base_hold ? rst_mono[7:0] : mono_wr[7:0]};
    assign next_dac_a  = dac_hold ? `CMX_RST_DAC_A : (wr_dac_a ? dac_merge : dac_a);
    assign next_enable = RST_IN ? `CMX_RST_ENABLE : (wr_en && WB_SEL_IN[0] ? WB_DAT_IN[3:0]
                                                                            : enable);

    // Register update
    always_ff @(posedge CLK_IN) begin
        aux3   <= next_aux3;
        mic    <= next_mic;
        mono   <= next_mono;
        dac_a  <= next_dac_a;
        enable <= next_enable;
    end

    // Status word shows pending changes and live hold gates
    wire [15:0] status_word;
    assign status_word = {11'h000,
                          dac_hold,
                          mix_hold,
                          base_hold,
                          pend_b,
                          pend_a};

    // Read mux; unmapped addresses answer zero
    wire [31:0] rd_word;
    assign rd_word = hit_aux3  ? {16'h0000, aux3} :
                     hit_mic   ? {16'h0000, mic} :
                     hit_mono  ? {16'h0000, mono} :
                     hit_dac_a ? {16'h0000, dac_a} :
                     hit_en    ? {28'h0000000, enable} :
                     hit_st    ? {16'h0000, status_word} :
                                 32'h00000000;

    // Single-wait-state slave: ack one cycle after the request, then drops
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            WB_ACK_OUT <= 1'b0;
            rd_data    <= 32'h00000000;
        end else begin
            WB_ACK_OUT <= req && !WB_ACK_OUT;
            rd_data    <= (req && !WB_ACK_OUT && !WB_WE_IN) ? rd_word : 32'h00000000;
        end
    end
    assign WB_DAT_OUT = rd_data;

    // Timing bits taken from the misc byte
    wire dac_a_now = mono[`CMX_DAC_A_TIME_BIT];
    wire dac_b_now = mono[`CMX_DAC_B_TIME_BIT];

    // DAC A gain reaches the outputs through the deferral unit
    cmx_gain_defer #(
        .TIMEOUT_CYCLES (DEFER_CYCLES),
        .RESET_VAL      (`CMX_RST_DAC_A)
    ) u_defer_a (
        .clk_in        (CLK_IN),
        .rst_in        (RST_IN),
        .force_in      (dac_hold),
        .value_in      (dac_merge),
        .load_in       (dac_a_ld),
        .immediate_in  (dac_a_now),
        .zero_cross_in (DAC_A_ZERO_CROSS_IN),
        .applied_out   (dac_a_applied),
        .pending_out   (pend_a)
    );

    // DAC B word lives elsewhere; only its timing is owned here
    cmx_gain_defer #(
        .TIMEOUT_CYCLES (DEFER_CYCLES),
        .RESET_VAL      (`CMX_RST_DAC_B)
    ) u_defer_b (
        .clk_in        (CLK_IN),
        .rst_in        (RST_IN),
        .force_in      (base_hold),
        .value_in      (DAC_B_GAIN_IN),
        .load_in       (DAC_B_GAIN_LOAD_IN && !base_hold),
        .immediate_in  (dac_b_now),
        .zero_cross_in (DAC_B_ZERO_CROSS_IN),
        .applied_out   (dac_b_applied),
        .pending_out   (pend_b)
    );

    // Misc controls decoded from the next value, so outputs track the register
    wire global_mute = next_mono[`CMX_GLOBAL_MUTE_BIT];

    // Global mute overrides every individual mix mute
    cmx_pkg::cmx_mix_s [1:0]       next_mic_out;
    cmx_pkg::cmx_dac_split_s [1:0] next_dac_out;
    cmx_pkg::cmx_mix_s             next_aux3_out;
    cmx_pkg::cmx_mix_s             next_mono_in;

    // Per channel decode: index 1 is the upper byte (left)
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        wire [7:0] mic_byte = next_mic[ch*8 +: 8];
        wire [7:0] gain_byte = dac_a_applied[ch*8 +: 8];
        wire [5:0] code = gain_byte[`CMX_DAC_GAIN_MSB:0];
        assign next_mic_out[ch].mute = mic_byte[`CMX_MUTE_BIT] || global_mute;
        assign next_mic_out[ch].gain = mic_byte[`CMX_MIX_GAIN_MSB:0];
        assign next_dac_out[ch].mute = gain_byte[`CMX_MUTE_BIT];
        // Analog bottoms out at code 11111; beyond that digital steps take over
        assign next_dac_out[ch].analog = code[5] ? 5'h1f : code[4:0];
        assign next_dac_out[ch].digital = code[5] ? ({1'b0, code[4:0]} + 6'h01)
                                                  : 6'h00;
    end

    // Right aux3 uses the low byte only
    assign next_aux3_out.mute = next_aux3[`CMX_MUTE_BIT] || global_mute;
    assign next_aux3_out.gain = next_aux3[`CMX_MIX_GAIN_MSB:0];

    // One mono mute and gain feed both sides of the mix
    assign next_mono_in.mute = next_mono[8 + `CMX_MUTE_BIT] || global_mute;
    assign next_mono_in.gain = next_mono[8 + `CMX_MIX_GAIN_MSB:8];

    // Output flops; under reset the next values are the defaults
    always_ff @(posedge CLK_IN) begin
        MIC_MIX_OUT               <= next_mic_out;
        RIGHT_AUX3_MIX_OUT        <= next_aux3_out;
        MONO_IN_MIX_OUT           <= next_mono_in;
        SUMMING_PINS_MIX_MUTE_OUT <= next_mono[`CMX_SUM_MUTE_BIT] || global_mute;
        GLOBAL_MIX_MUTE_OUT       <= global_mute;
        MONO_OUT_MUTE_OUT         <= next_mono[`CMX_MONO_OUT_BIT];
        HEADPHONE_OUT_MUTE_OUT    <= next_mono[`CMX_HP_MUTE_BIT];
        HEADPHONE_SWING_OUT       <= next_mono[`CMX_HP_SWING_BIT];
        DAC_A_OUT                 <= next_dac_out;
        DAC_B_GAIN_OUT            <= dac_b_applied;
    end

endmodule

// ---- rtl/cmx_pkg.sv ----
// Types shared by the mixer control bank files
package cmx_pkg;

    // One mix path: mute and 5-bit gain code
    typedef struct packed {
        logic       mute;
        logic [4:0] gain;
    } cmx_mix_s;

    // One output channel split into analog and digital steps
    typedef struct packed {
        logic       mute;
        logic [4:0] analog;
        logic [5:0] digital;
    } cmx_dac_split_s;

    // Deferred gain change states
    typedef enum logic {
        CMX_IDLE,
        CMX_WAIT
    } cmx_defer_e;

endpackage
